// ---- hdl/tsp_slave.sv ----
/*
  device end: two-wire slave giving access to a register array.
  assumes a master obeying the 400 kHz limit; index 0 is read-only bus address.
*/
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_slave (
  input wire logic sys_clk,
  input wire logic rst_n,
  tsp_bus_if.slave bus,
  input wire logic addr_select_pin,
  output logic bus_busy,
  output logic wr_stb,
  output tsp_pkg::tsp_byte_t wr_index,
  output tsp_pkg::tsp_byte_t wr_data
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } tsp_sst_e;
  tsp_sst_e st_reg;
  logic scl;
  logic sda;
  logic scl_d_reg;
  logic sda_d_reg;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic [3:0] bit_reg;
  tsp_pkg::tsp_byte_t sh_reg;
  tsp_pkg::tsp_byte_t index_reg;
  logic [1:0] phase_reg;
  logic read_reg;
  logic ack_ok_reg;
  logic sda_oe_n_reg;
  logic addr_lsb_reg;
  tsp_pkg::tsp_byte_t mem [`TSP_REG_DEPTH];
  tsp_pkg::tsp_addr_t own_addr;
  tsp_pkg::tsp_byte_t rd_byte;

  //////////////////////////////////////////////////////////////////////////////
  tsp_sync #(.INIT(1'b1)) u_scl (.sys_clk(sys_clk), .rst_n(rst_n), .pin(bus.scl), .level(scl));
  tsp_sync #(.INIT(1'b1)) u_sda (.sys_clk(sys_clk), .rst_n(rst_n), .pin(bus.sda), .level(sda));
  tsp_sync #(.INIT(1'b0)) u_ad (.sys_clk(sys_clk), .rst_n(rst_n), .pin(addr_select_pin),
    .level(addr_lsb_reg));

  // edges on the conditioned lines
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end
  assign start_ev = scl && scl_d_reg && sda_d_reg && !sda; // R6 R8
  assign stop_ev = scl && scl_d_reg && !sda_d_reg && sda; // R7
  assign scl_rise = scl && !scl_d_reg;
  assign scl_fall = !scl && scl_d_reg;
  assign own_addr = {`TSP_ADDR_UPPER, addr_lsb_reg}; // R3 R4
  // index zero answers with the live bus address
  assign rd_byte = (index_reg == `TSP_REG_BUS_ADDRESS_ID) ? {1'b0, own_addr} : mem[index_reg]; // R5
  // never stretches: logic is far faster than the bus, so scl stays released
  assign bus.s_scl_oe_n = 1'b1; // R1 R11
  assign bus.s_sda_oe_n = sda_oe_n_reg; // R18

  //////////////////////////////////////////////////////////////////////////////
  // busy flag between start and stop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_busy <= 1'b0;
    end else if (start_ev) begin
      bus_busy <= 1'b1; // R6 R8
    end else if (stop_ev) begin
      bus_busy <= 1'b0; // R7
    end
  end

  // protocol engine: phase 0 address, 1 index, 2 data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= ST_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      index_reg <= 8'h00;
      phase_reg <= 2'h0;
      read_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      wr_stb <= 1'b0;
      wr_index <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_ev) begin
        st_reg <= ST_RX; // R8
        bit_reg <= 4'h0;
        phase_reg <= 2'h0;
        sda_oe_n_reg <= 1'b1;
      end else if (stop_ev) begin
        st_reg <= ST_IDLE; // R7
        sda_oe_n_reg <= 1'b1;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            sda_oe_n_reg <= 1'b1;
          end
          ST_RX: begin
            if (scl_rise) begin
              sh_reg <= {sh_reg[6:0], sda}; // R13
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin // R9
              bit_reg <= 4'h0;
              st_reg <= ST_ACK;
              ack_ok_reg <= 1'b1;
              if (phase_reg == 2'h0) begin
                if (sh_reg[7:1] == own_addr) begin
                  read_reg <= sh_reg[0]; // R14 R19
                  sda_oe_n_reg <= 1'b0; // R10
                end else begin
                  st_reg <= ST_IDLE; // R22
                  ack_ok_reg <= 1'b0;
                end
              end else if (phase_reg == 2'h1) begin
                index_reg <= sh_reg; // R15
                sda_oe_n_reg <= 1'b0; // R10
              end else begin
                if (index_reg != `TSP_REG_BUS_ADDRESS_ID) begin
                  mem[index_reg] <= sh_reg; // R15
                end
                wr_stb <= 1'b1;
                wr_index <= index_reg;
                wr_data <= sh_reg;
                index_reg <= index_reg + 8'h01; // R16
                sda_oe_n_reg <= 1'b0; // R10
              end
            end
          end
          ST_ACK: begin
            // release after the ninth clock, or start driving read data
            if (scl_fall) begin
              if (phase_reg == 2'h0 && read_reg) begin
                st_reg <= ST_TX;
                sda_oe_n_reg <= rd_byte[7]; // R19
                sh_reg <= {rd_byte[6:0], 1'b0};
                bit_reg <= 4'h1;
              end else begin
                st_reg <= ST_RX;
                sda_oe_n_reg <= 1'b1;
                if (phase_reg != 2'h2) begin
                  phase_reg <= phase_reg + 2'h1;
                end
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_reg == 4'h8) begin
                st_reg <= ST_MACK;
                sda_oe_n_reg <= 1'b1; // R20
                index_reg <= index_reg + 8'h01; // R21
              end else begin
                sda_oe_n_reg <= sh_reg[7]; // R13
                sh_reg <= {sh_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ack_ok_reg <= !sda;
            end else if (scl_fall) begin
              if (ack_ok_reg) begin
                st_reg <= ST_TX; // R21
                sda_oe_n_reg <= rd_byte[7];
                sh_reg <= {rd_byte[6:0], 1'b0};
                bit_reg <= 4'h1;
              end else begin
                st_reg <= ST_IDLE; // R20
              end
            end
          end
        endcase
      end
    end
  end
endmodule : tsp_slave

// ---- hdl/tsp_regs.svh ----
/*
  constants for the two-wire register port: addresses, offsets, timing counts.
  assumes a 50 MHz system clock and a bus master running at most 400 kHz.
*/
// Summary of operation
// R1 - device is slave only, never drives clock
// R2 - bus clock at most 400 kHz
// R3 - address upper six bits fixed 110100
// R4 - address lsb follows select pin
// R5 - register zero returns own bus address
// R6 - sda fall with scl high starts
// R7 - sda rise with scl high stops
// R8 - repeated start keeps bus busy
// R9 - eight bits then one acknowledge
// R10 - receiver holds sda low for ack
// R11 - busy slave may stretch scl low
// R12 - master sends address, direction, awaits ack
// R13 - sda changes only while scl low
// R14 - write: address with direction zero, ack
// R15 - index then data, ack each, store
// R16 - burst write increments register index
// R17 - master ends with stop or restart
// R18 - both lines open drain, pulled high
// R19 - read: index write, restart, read address
// R20 - master acks more, nacks last, stops
// R21 - burst read increments index on ack; slave increments after every sent byte, acked or not
// R22 - address mismatch gets no ack, ignored
`ifndef TSP_REGS_SVH
`define TSP_REGS_SVH
`define TSP_ADDR_UPPER 6'h34
`define TSP_REG_BUS_ADDRESS_ID 8'h00
`define TSP_CLK_HZ 50000000
`define TSP_SCL_MAX_KHZ 400
// quarter period of scl in sys_clk cycles as the master uses it, rounded up so the bus is never too fast
`define TSP_SCL_HALF_CYC ((`TSP_CLK_HZ + 2*`TSP_SCL_MAX_KHZ*1000 - 1) / (2*`TSP_SCL_MAX_KHZ*1000))
`define TSP_REG_DEPTH 256
`endif

// ---- hdl/tsp_pkg.sv ----
/*
  types used by the slave end of the register port and by the bench.
  assumes tsp_regs.svh supplies the numbers.
*/
package tsp_pkg;
  typedef logic [7:0] tsp_byte_t;
  typedef logic [6:0] tsp_addr_t;
endpackage : tsp_pkg

// ---- hdl/tsp_bus_if.sv ----
/*
  two-wire bus carrier: open-drain resolution of scl and sda.
  assumes each party drives oe low to pull a line low; pull-ups otherwise.
*/
`timescale 1ns/1ps
interface tsp_bus_if;
  logic m_scl_oe_n;
  logic m_sda_oe_n;
  logic s_scl_oe_n;
  logic s_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and of both parties, pulled high when released
  assign scl = m_scl_oe_n & s_scl_oe_n; // R18
  assign sda = m_sda_oe_n & s_sda_oe_n; // R18
  modport master (output m_scl_oe_n, output m_sda_oe_n, input scl, input sda);
  modport slave (output s_scl_oe_n, output s_sda_oe_n, input scl, input sda);
endinterface : tsp_bus_if

// ---- hdl/tsp_sync.sv ----
/*
  three-flop input conditioner for a pin; output moves when stages two and three agree.
  assumes a free running sys_clk.
*/
`timescale 1ns/1ps
module tsp_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // stage one is read only by stage two
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // hold last agreed value to reject a single-sample glitch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level <= INIT;
    end else if (s2_reg == s3_reg) begin
      level <= s3_reg;
    end
  end
endmodule : tsp_sync

// ---- hdl/tsp_master.sv ----
/*
  far end: two-wire master taking orders through a small register port.
  assumes one slave per transfer; software polls the status register.
*/
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_master #(
  parameter int HALF_CYC = `TSP_SCL_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  tsp_bus_if.master bus,
  input wire logic [1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata
);
  // cmd bits: 0 start, 1 write byte, 2 read byte, 3 stop, 4 nack on read
  typedef enum logic [4:0] {
    MS_IDLE = 5'h01,
    MS_START = 5'h02,
    MS_BIT = 5'h04,
    MS_STOP = 5'h08,
    MS_DONE = 5'h10
  } tsp_mst_e;
  tsp_mst_e st_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [4:0] cmd_reg;
  logic nack_reg;
  logic busy;
  logic [3:0] bit_reg;
  logic [1:0] ph_reg;
  logic [15:0] div_reg;
  logic tick;
  logic scl_oe_n_reg;
  logic sda_oe_n_reg;

  assign busy = (st_reg != MS_IDLE);
  assign tick = (div_reg == 16'(HALF_CYC - 1)); // R2
  assign bus.m_scl_oe_n = scl_oe_n_reg; // R18
  assign bus.m_sda_oe_n = sda_oe_n_reg; // R18

  //////////////////////////////////////////////////////////////////////////////
  // quarter-bit divider; halts while a slave holds scl low
  always_ff @(posedge sys_clk) begin
    if (!rst_n || st_reg == MS_IDLE) begin
      div_reg <= 16'h0000;
    end else if (scl_oe_n_reg && !bus.scl) begin
      div_reg <= 16'h0000; // R11
    end else if (tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // register reads: 0 tx, 1 rx, 2 status
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      unique case (cpu_addr)
        2'h0: cpu_rdata <= tx_reg;
        2'h1: cpu_rdata <= rx_reg;
        2'h2: cpu_rdata <= {6'h00, nack_reg, busy};
        default: cpu_rdata <= 8'h00;
      endcase
    end else begin
      cpu_rdata <= 8'h00;
    end
  end

  // tx data register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_reg <= 8'h00;
    end else if (cpu_wr && cpu_addr == 2'h0) begin
      tx_reg <= cpu_wdata;
    end
  end

  // sequencer: each phase lasts one divider period
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= MS_IDLE;
      cmd_reg <= 5'h00;
      rx_reg <= 8'h00;
      nack_reg <= 1'b0;
      bit_reg <= 4'h0;
      ph_reg <= 2'h0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else begin
      unique case (st_reg)
        MS_IDLE: begin
          if (cpu_wr && cpu_addr == 2'h3) begin
            cmd_reg <= cpu_wdata[4:0];
            ph_reg <= 2'h0;
            bit_reg <= 4'h0;
            st_reg <= cpu_wdata[0] ? MS_START : (cpu_wdata[2:1] != 2'h0) ? MS_BIT : MS_STOP;
          end
        end
        MS_START: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            // release both, then sda low with scl high, then scl low
            unique case (ph_reg)
              2'h0: begin
                sda_oe_n_reg <= 1'b1;
              end
              2'h1: begin
                scl_oe_n_reg <= 1'b1;
              end
              2'h2: begin
                sda_oe_n_reg <= 1'b0; // R6 R8
              end
              2'h3: begin
                scl_oe_n_reg <= 1'b0;
                st_reg <= (cmd_reg[2:1] != 2'h0) ? MS_BIT : MS_DONE; // R12
              end
            endcase
          end
        end
        MS_BIT: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            unique case (ph_reg)
              2'h0: begin
                // data set only while scl low; bit 8 is the acknowledge slot
                if (bit_reg == 4'h8) begin
                  sda_oe_n_reg <= cmd_reg[1] ? 1'b1 : cmd_reg[4]; // R10 R20
                end else begin
                  sda_oe_n_reg <= cmd_reg[1] ? tx_reg[3'(7 - bit_reg)] : 1'b1; // R13
                end
              end
              2'h1: begin
                scl_oe_n_reg <= 1'b1;
              end
              2'h2: begin
                if (bit_reg == 4'h8) begin
                  nack_reg <= cmd_reg[1] ? bus.sda : 1'b0; // R10
                end else begin
                  rx_reg <= {rx_reg[6:0], bus.sda};
                end
              end
              2'h3: begin
                scl_oe_n_reg <= 1'b0;
                bit_reg <= bit_reg + 4'h1;
                if (bit_reg == 4'h8) begin // R9
                  st_reg <= cmd_reg[3] ? MS_STOP : MS_DONE;
                  bit_reg <= 4'h0;
                end
              end
            endcase
          end
        end
        MS_STOP: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            unique case (ph_reg)
              2'h0: begin
                sda_oe_n_reg <= 1'b0;
              end
              2'h1: begin
                scl_oe_n_reg <= 1'b1;
              end
              2'h2: begin
                sda_oe_n_reg <= 1'b1; // R7 R17
              end
              2'h3: begin
                st_reg <= MS_DONE;
              end
            endcase
          end
        end
        MS_DONE: begin
          st_reg <= MS_IDLE;
        end
        default: begin
          st_reg <= MS_IDLE;
        end
      endcase
    end
  end
endmodule : tsp_master

// ---- tb/tsp_bus_sva.sv ----
/*
  checker for the two-wire bus joining the master and slave ends.
  assumes one sys_clk domain, synchronous active-low reset, pulled-up lines.
*/
`timescale 1ns/1ps
`include "tsp_regs.svh"
module tsp_bus_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic m_scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic s_scl_oe_n,
  input wire logic s_sda_oe_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic bus_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // shortest legal scl period in sys_clk cycles, from the bus rate limit
  localparam int MIN_PERIOD = `TSP_CLK_HZ / (`TSP_SCL_MAX_KHZ * 1000);
  ////////////////////////////////////////////////////////////////////////////
  logic scl_q;
  logic [15:0] rise_gap;
  // cycles since the last scl rise; saturates so long idle spans never wrap
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      rise_gap <= 16'hFFFF;
    end else begin
      scl_q <= scl;
      if (scl && !scl_q) rise_gap <= 16'h0001;
      else if (rise_gap != 16'hFFFF) rise_gap <= rise_gap + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_slave_no_clock; s_scl_oe_n; endproperty
  a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drove scl");
  property p_wired; sda == (m_sda_oe_n & s_sda_oe_n) && scl == (m_scl_oe_n & s_scl_oe_n);
  endproperty
  a_wired: assert property (p_wired) else $error("line level not wired and");
  property p_rate; (scl && !scl_q) |-> rise_gap >= MIN_PERIOD; endproperty
  a_rate: assert property (p_rate) else $error("scl rises too close together");
  property p_start_busy; ($fell(sda) && scl) |-> ##[1:10] bus_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not seen");
  property p_stop_free; ($rose(sda) && scl) |-> ##[1:10] !bus_busy; endproperty
  a_stop_free: assert property (p_stop_free) else $error("stop did not free bus");
  property p_restart_busy; ($fell(sda) && scl && bus_busy) |-> bus_busy [*8]; endproperty
  a_restart_busy: assert property (p_restart_busy) else $error("restart freed bus");
  property p_sda_change_low; $changed(s_sda_oe_n) |-> !scl; endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("slave sda moved, scl high");
  property p_ack_hold; (!s_sda_oe_n && $rose(scl)) |=> !sda [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low bit not held while scl high");
  property p_idle_release; !bus_busy |-> s_sda_oe_n; endproperty
  a_idle_release: assert property (p_idle_release) else $error("slave drives idle bus");
  // main scenarios: acknowledged bit, repeated start, stop
  c_ack: cover property (!s_sda_oe_n && $rose(scl));
  c_restart: cover property ($fell(sda) && scl && bus_busy);
  c_stop: cover property ($rose(sda) && scl);
endmodule : tsp_bus_sva

// ---- tb/i2c_slave_register_port_tb.sv ----
/*
  self-checking bench: master end and slave end joined by the bus carrier.
  assumes a 50 MHz sys_clk and the master's command register map.
*/
`timescale 1ns/1ps
module i2c_slave_register_port_tb;
  // quarter-bit of 32 cycles: 128-cycle scl period, just inside the rate limit
  localparam int HALF = 32;
  logic sys_clk;
  logic rst_n;
  logic addr_select_pin;
  logic [1:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_wr;
  logic cpu_rd;
  logic [7:0] cpu_rdata;
  logic bus_busy;
  logic wr_stb;
  tsp_pkg::tsp_byte_t wr_index;
  tsp_pkg::tsp_byte_t wr_data;
  logic [15:0] rx;
  logic [15:0] nack;
  logic [7:0] bad [2];
  int err_count;
  int checked;
  logic [15:0] stored [$];
  ////////////////////////////////////////////////////////////////////////////
  tsp_bus_if tsp_bus_if_inst ();
  tsp_slave tsp_slave_inst (.sys_clk(sys_clk), .rst_n(rst_n), .bus(tsp_bus_if_inst.slave),
    .addr_select_pin(addr_select_pin), .bus_busy(bus_busy), .wr_stb(wr_stb),
    .wr_index(wr_index), .wr_data(wr_data));
  tsp_master #(.HALF_CYC(HALF)) tsp_master_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus(tsp_bus_if_inst.master), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
  tsp_bus_sva tsp_bus_sva_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .m_scl_oe_n(tsp_bus_if_inst.m_scl_oe_n), .m_sda_oe_n(tsp_bus_if_inst.m_sda_oe_n),
    .s_scl_oe_n(tsp_bus_if_inst.s_scl_oe_n), .s_sda_oe_n(tsp_bus_if_inst.s_sda_oe_n),
    .scl(tsp_bus_if_inst.scl), .sda(tsp_bus_if_inst.sda), .bus_busy(bus_busy));
  ////////////////////////////////////////////////////////////////////////////
  // free running 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // every stored byte leaves one strobe; keep index and data for later
  always @(posedge sys_clk) begin
    if (wr_stb === 1'b1) stored.push_back({wr_index, wr_data});
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // one-cycle strobes, a free cycle between calls so no strobe is set twice
  task automatic cpu_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
  endtask : cpu_write
  task automatic cpu_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    #1 d = cpu_rdata;
  endtask : cpu_read
  // one master command: load tx if sent, issue command, poll busy, fetch results
  task automatic op(input logic [7:0] cmd, input logic [7:0] tx);
    logic [7:0] st;
    logic [7:0] d;
    int n;
    st = 8'hFF;
    n = 0;
    if (cmd[1]) cpu_write(2'h0, tx);
    cpu_write(2'h3, cmd);
    while (st[0] !== 1'b0 && n < 3000) begin
      cpu_read(2'h2, st);
      n++;
    end
    if (n >= 3000) check(16'h0001, 16'h0000, "master stayed busy");
    nack = {15'h0000, st[1]};
    cpu_read(2'h1, d);
    rx = {8'h00, d};
  endtask : op
  function automatic logic [7:0] adr(input logic rd);
    return {6'h34, addr_select_pin, rd};
  endfunction : adr
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, well beyond the ~35k cycles the sequence needs
  initial begin
    repeat (80000) @(posedge sys_clk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    rst_n = 1'b0;
    addr_select_pin = 1'b0;
    cpu_addr = 2'h0;
    cpu_wdata = 8'h00;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    err_count = 0;
    checked = 0;
    bad[0] = 8'h6A;
    bad[1] = 8'h50;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    // slave input flops need a few edges to settle to idle
    repeat (6) @(posedge sys_clk);
    op(8'h03, adr(1'b0));
    check(nack, 16'h0000, "write address ack");
    check({15'h0000, bus_busy}, 16'h0001, "busy after start");
    op(8'h02, 8'h05);
    check(nack, 16'h0000, "index ack");
    op(8'h02, 8'hA5);
    check(nack, 16'h0000, "data ack");
    op(8'h0A, 8'h5A);
    check(nack, 16'h0000, "burst data ack");
    repeat (10) @(posedge sys_clk);
    check({15'h0000, bus_busy}, 16'h0000, "busy after stop");
    check(16'(stored.size()), 16'h0002, "stored count");
    check(stored[0], 16'h05A5, "first store");
    check(stored[1], 16'h065A, "second store");
    $display("test burst write done");
    op(8'h03, adr(1'b0));
    op(8'h02, 8'h05);
    op(8'h03, adr(1'b1));
    check(nack, 16'h0000, "read address ack");
    check({15'h0000, bus_busy}, 16'h0001, "busy across restart");
    op(8'h04, 8'h00);
    check(rx, 16'h00A5, "first read byte");
    op(8'h1C, 8'h00);
    check(rx, 16'h005A, "second read byte");
    repeat (10) @(posedge sys_clk);
    check({15'h0000, bus_busy}, 16'h0000, "busy after read stop");
    $display("test burst read done");
    for (int i = 0; i < 2; i++) begin
      op(8'h03, bad[i]);
      check(nack, 16'h0001, "foreign address acked");
      op(8'h0A, 8'h11);
      check(nack, 16'h0001, "foreign data acked");
    end
    check(16'(stored.size()), 16'h0002, "foreign transfer stored");
    $display("test foreign address done");
    for (int s = 0; s < 2; s++) begin
      addr_select_pin <= s[0];
      repeat (8) @(posedge sys_clk);
      op(8'h03, adr(1'b0));
      op(8'h02, 8'h00);
      op(8'h0A, 8'hFF);
      op(8'h03, adr(1'b0));
      op(8'h02, 8'h00);
      op(8'h03, adr(1'b1));
      check(nack, 16'h0000, "selected address ack");
      op(8'h1C, 8'h00);
      check(rx, {9'h000, 6'h34, s[0]}, "address register");
    end
    check(16'(stored.size()), 16'h0004, "read-only strobes");
    $display("test address register done");
    // separate start-only and stop-only commands around one address byte
    op(8'h01, 8'h00);
    check({15'h0000, bus_busy}, 16'h0001, "busy after lone start");
    op(8'h02, adr(1'b0));
    check(nack, 16'h0000, "address ack after lone start");
    op(8'h08, 8'h00);
    repeat (10) @(posedge sys_clk);
    check({15'h0000, bus_busy}, 16'h0000, "busy after lone stop");
    $display("test start stop commands done");
    end_of_test();
  end
endmodule : i2c_slave_register_port_tb
